/* verilog/lsr_pkg.sv */
// package with field layouts, codes and sizes for the slave response framer
package lsr_pkg;
  // link status codes
  localparam logic [2:0] LSR_LINK_OK       = 3'h0;
  localparam logic [2:0] LSR_LINK_RESET    = 3'h1;
  localparam logic [2:0] LSR_LINK_DATA     = 3'h4;
  localparam logic [2:0] LSR_LINK_CHECKSUM = 3'h5;
  localparam logic [2:0] LSR_LINK_FRAMING  = 3'h6;
  localparam logic [2:0] LSR_LINK_PARITY   = 3'h7;
  // fault class codes
  localparam logic [1:0] LSR_FAULT_NONE    = 2'h0;
  localparam logic [1:0] LSR_FAULT_OVERTMP = 2'h2;
  localparam logic [1:0] LSR_FAULT_NVMPRG  = 2'h3;
  // status byte field positions
  localparam int LSR_POS_TEMP   = 0;
  localparam int LSR_POS_SPARE  = 1;
  localparam int LSR_POS_FAULT  = 2;
  localparam int LSR_POS_UNCFG  = 4;
  localparam int LSR_POS_LINK   = 5;
  // readback address counter
  localparam int         LSR_ADDR_W     = 5;
  localparam logic [4:0] LSR_ADDR_RESET = 5'h00;
  localparam logic [4:0] LSR_ADDR_LAST  = 5'h10;
  localparam logic [7:0] LSR_LOC_DEFAULT = 8'hFF; // arbitrary default location code
  // frame lengths in data bytes
  localparam logic [2:0] LSR_LEN_STATUS   = 3'h2;
  localparam logic [2:0] LSR_LEN_READBACK = 3'h5;
  localparam logic [7:0] LSR_PID_STATUS   = 8'h00; // arbitrary default identifier
  localparam logic [7:0] LSR_PID_READBACK = 8'h00; // arbitrary default identifier
  // frame event codes from the link layer
  localparam logic [2:0] LSR_EV_OK       = 3'h0;
  localparam logic [2:0] LSR_EV_DATA     = 3'h4;
  localparam logic [2:0] LSR_EV_CHECKSUM = 3'h5;
  localparam logic [2:0] LSR_EV_FRAMING  = 3'h6;
  localparam logic [2:0] LSR_EV_PARITY   = 3'h7;
endpackage

/* verilog/lsr_checksum.sv */
// enhanced checksum accumulator for response bytes
`timescale 1ns/1ps
`default_nettype none
module lsr_checksum
  import lsr_pkg::*;
(
  input  wire logic       clk,      // system clock
  input  wire logic       rst,      // async reset
  input  wire logic       clear,    // restart with a seed byte
  input  wire logic [7:0] seed,     // protected identifier
  input  wire logic       add,      // add one data byte
  input  wire logic [7:0] data,     // data byte to add
  output logic      [7:0] csum      // inverted running sum
);
  logic [7:0] sum_q;
  logic [7:0] sum_d;
  logic [8:0] wide;

  // carry-around eight bit addition
  always_comb begin
    wide  = {1'b0, sum_q} + {1'b0, data};
    sum_d = sum_q;
    if (clear) begin
      sum_d = seed;
    end else if (add) begin
      sum_d = wide[7:0] + {7'h00, wide[8]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum_q <= 8'h00;
    end else begin
      sum_q <= sum_d;
    end
  end

  assign csum = ~sum_q;
endmodule
`default_nettype wire

/* verilog/lsr_avalon_regs.sv */
// avalon slave with control and status registers of the framer
`timescale 1ns/1ps
`default_nettype none
module lsr_avalon_regs
  import lsr_pkg::*;
(
  input  wire logic        clk,            // system clock
  input  wire logic        rst,            // async reset
  input  wire logic [3:0]  address,        // word address
  input  wire logic        read,           // read strobe
  input  wire logic        write,          // write strobe
  input  wire logic [31:0] writedata,      // write data
  input  wire logic [3:0]  byteenable,     // byte lanes
  output logic      [31:0] readdata,       // read data
  output logic             waitrequest,    // stall
  output logic      [7:0]  location_code,  // node location code
  output logic             configured,     // location was written
  output logic      [7:0]  pid_status,     // identifier of status frame
  output logic      [7:0]  pid_readback,   // identifier of readback frame
  input  wire logic [31:0] status_word     // framer state to read
);
  localparam logic [3:0] LSR_REG_LOC    = 4'h0;
  localparam logic [3:0] LSR_REG_PID    = 4'h1;
  localparam logic [3:0] LSR_REG_STATUS = 4'h2;

  logic        ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic [7:0]  loc_q, loc_d, ps_q, ps_d, pr_q, pr_d;
  logic        cfg_q, cfg_d;

  // one wait cycle then acknowledge; unmapped reads give zero
  always_comb begin
    ack_d = (read | write) & ~ack_q;
    rd_d  = rd_q;
    loc_d = loc_q;
    cfg_d = cfg_q;
    ps_d  = ps_q;
    pr_d  = pr_q;
    if (read & ~ack_q) begin
      unique case (address)
        LSR_REG_LOC:    rd_d = {23'h000000, cfg_q, loc_q};
        LSR_REG_PID:    rd_d = {16'h0000, pr_q, ps_q};
        LSR_REG_STATUS: rd_d = status_word;
        default:        rd_d = 32'h00000000;
      endcase
    end
    // writes land at the accepting edge, when waitrequest is low
    if (write & ack_q) begin
      if (address == LSR_REG_LOC && byteenable[0]) begin
        loc_d = writedata[7:0];
        cfg_d = 1'b1;
      end
      if (address == LSR_REG_PID && byteenable[0]) ps_d = writedata[7:0];
      if (address == LSR_REG_PID && byteenable[1]) pr_d = writedata[15:8];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rd_q  <= 32'h00000000;
      loc_q <= LSR_LOC_DEFAULT;
      cfg_q <= 1'b0;
      ps_q  <= LSR_PID_STATUS;
      pr_q  <= LSR_PID_READBACK;
    end else begin
      ack_q <= ack_d;
      rd_q  <= rd_d;
      loc_q <= loc_d;
      cfg_q <= cfg_d;
      ps_q  <= ps_d;
      pr_q  <= pr_d;
    end
  end

  assign waitrequest   = (read | write) & ~ack_q;
  assign readdata      = rd_q;
  assign location_code = loc_q;
  assign configured    = cfg_q;
  assign pid_status    = ps_q;
  assign pid_readback  = pr_q;
endmodule
`default_nettype wire

/* verilog/lsr_framer.sv */
// slave status and memory readback response framer
// Operation
// RULE_01: status data byte 2 carries location code
// RULE_02: bit 0 is temperature warning flag
// RULE_03: bit 1 always reads low
// RULE_04: bits 3:2 carry fault class code
// RULE_05: bit 4 high while node unconfigured
// RULE_06: link code 0 after clean frame
// RULE_07: link code 1 first after reset
// RULE_08: checksum error discards frame, reports 5
// RULE_09: codes 4, 6, 7; never 2, 3
// RULE_10: master fetches memory via readback header
// RULE_11: readback uses enhanced checksum including identifier
// RULE_12: one memory register per readback response
// RULE_13: counter increments after successful readback
// RULE_14: reset clears readback counter
// RULE_15: memory write loads counter with address; skipped if a checksum error ends a frame in the same cycle
// RULE_16: register bytes low, mid, high in 3-5
// RULE_17: data byte 2 holds counter, upper unused
// RULE_18: readback byte 1 repeats status layout
// RULE_19: failed readback leaves counter unchanged
// RULE_20: link code updates after each frame
`timescale 1ns/1ps
`default_nettype none
module lsr_framer
  import lsr_pkg::*;
(
  input  wire logic        clk,             // system clock
  input  wire logic        rst,             // async reset
  input  wire logic [3:0]  address,         // avalon word address
  input  wire logic        read,            // avalon read
  input  wire logic        write,           // avalon write
  input  wire logic [31:0] writedata,       // avalon write data
  input  wire logic [3:0]  byteenable,      // avalon byte enables
  output logic      [31:0] readdata,        // avalon read data
  output logic             waitrequest,     // avalon stall
  input  wire logic        temp_warning,    // temperature warning level
  input  wire logic [1:0]  fault_class,     // fault class level
  input  wire logic        status_request,  // pulse: status header seen
  input  wire logic        readback_request,// pulse: readback header seen
  input  wire logic        frame_done,      // pulse: frame finished
  input  wire logic [2:0]  frame_result,    // outcome with frame_done
  input  wire logic        write_done,      // pulse: memory write command done
  input  wire logic [4:0]  write_address,   // address programmed last
  output logic      [4:0]  mem_address,     // memory address selected
  input  wire logic [23:0] mem_data,        // memory register contents
  output logic             tx_valid,        // response byte valid
  output logic      [7:0]  tx_byte,         // response byte
  output logic             tx_last,         // last byte (checksum)
  input  wire logic        tx_ready         // link takes byte
);
  typedef enum logic [2:0] {
    LSR_IDLE = 3'b001,
    LSR_SEND = 3'b010,
    LSR_SUM  = 3'b100
  } lsr_state_e;

  lsr_state_e  st_q, st_d;
  logic [2:0]  link_q, link_d;
  logic [4:0]  addr_q, addr_d;
  logic        rb_q, rb_d;          // current response is readback
  logic        pend_q, pend_d;      // readback response awaiting outcome
  logic [2:0]  idx_q, idx_d;
  logic        v_q, v_d, l_q, l_d;
  logic [7:0]  b_q, b_d;
  logic [39:0] img_q, img_d;        // response bytes, byte 1 lowest
  logic [7:0]  loc;
  logic        cfg;
  logic [7:0]  pid_s, pid_r;
  logic        cs_clear, cs_add;
  logic [7:0]  cs_seed, csum;
  logic [7:0]  info;

  // build the shared status byte
  function automatic logic [7:0] lsr_status_byte(input logic [2:0] link, input logic unc,
                                                 input logic [1:0] flt, input logic tw);
    logic [7:0] s;
    s = 8'h00;
    s[LSR_POS_TEMP]                 = tw;        // [RULE_02]
    s[LSR_POS_SPARE]                = 1'b0;      // [RULE_03]
    s[LSR_POS_FAULT +: 2]           = flt;       // [RULE_04]
    s[LSR_POS_UNCFG]                = unc;       // [RULE_05]
    s[LSR_POS_LINK +: 3]            = link;      // [RULE_18]
    return s;
  endfunction

  // map a frame outcome onto the link status code
  function automatic logic [2:0] lsr_link_code(input logic [2:0] ev);
    logic [2:0] c;
    c = LSR_LINK_DATA;
    unique case (ev)
      LSR_EV_OK:       c = LSR_LINK_OK;        // [RULE_06]
      LSR_EV_CHECKSUM: c = LSR_LINK_CHECKSUM;  // [RULE_08]
      LSR_EV_FRAMING:  c = LSR_LINK_FRAMING;   // [RULE_09]
      LSR_EV_PARITY:   c = LSR_LINK_PARITY;    // [RULE_09]
      default:         c = LSR_LINK_DATA;      // [RULE_09]
    endcase
    return c;
  endfunction

  lsr_avalon_regs u_regs (
    .clk           (clk),
    .rst           (rst),
    .address       (address),
    .read          (read),
    .write         (write),
    .writedata     (writedata),
    .byteenable    (byteenable),
    .readdata      (readdata),
    .waitrequest   (waitrequest),
    .location_code (loc),
    .configured    (cfg),
    .pid_status    (pid_s),
    .pid_readback  (pid_r),
    .status_word   ({8'h00, 3'h0, addr_q, info, loc})
  );

  lsr_checksum u_sum (
    .clk   (clk),
    .rst   (rst),
    .clear (cs_clear),
    .seed  (cs_seed),
    .add   (cs_add),
    .data  (b_d),
    .csum  (csum)
  );

  assign info = lsr_status_byte(link_q, ~cfg, fault_class, temp_warning);

  // link status and readback counter bookkeeping
  always_comb begin
    link_d = link_q;
    addr_d = addr_q;
    pend_d = pend_q;
    if (frame_done) begin
      link_d = lsr_link_code(frame_result);                   // [RULE_20]
      if (pend_q && frame_result == LSR_EV_OK) begin
        addr_d = (addr_q == LSR_ADDR_LAST) ? LSR_ADDR_RESET : addr_q + 5'h01; // [RULE_13]
      end                                                     // [RULE_19]
      pend_d = 1'b0;
    end
    if (write_done && !(frame_done && frame_result == LSR_EV_CHECKSUM)) begin
      addr_d = write_address;                                 // [RULE_15]
    end
    if (st_q == LSR_SUM && tx_ready && rb_q) begin
      pend_d = 1'b1;
    end
  end

  // response sequencer: data bytes then checksum
  always_comb begin
    st_d     = st_q;
    rb_d     = rb_q;
    idx_d    = idx_q;
    img_d    = img_q;
    v_d      = v_q;
    l_d      = l_q;
    b_d      = b_q;
    cs_clear = 1'b0;
    cs_seed  = pid_s;
    cs_add   = 1'b0;
    unique case (st_q)
      LSR_IDLE: begin
        if (readback_request) begin
          // [RULE_12] [RULE_16] [RULE_17] [RULE_18]
          img_d    = {mem_data[23:16], mem_data[15:8], mem_data[7:0], 3'h0, addr_q, info};
          rb_d     = 1'b1;
          cs_seed  = pid_r;                                   // [RULE_11]
          cs_clear = 1'b1;
          idx_d    = LSR_LEN_READBACK;
          st_d     = LSR_SEND;
        end else if (status_request) begin
          img_d    = {24'h000000, loc, info};                 // [RULE_01]
          rb_d     = 1'b0;
          cs_seed  = pid_s;
          cs_clear = 1'b1;
          idx_d    = LSR_LEN_STATUS;
          st_d     = LSR_SEND;
        end
      end
      LSR_SEND: begin
        if (!v_q || tx_ready) begin
          if (idx_q == 3'h0) begin
            v_d  = 1'b1;
            l_d  = 1'b1;
            b_d  = csum;                                      // [RULE_11]
            st_d = LSR_SUM;
          end else begin
            v_d    = 1'b1;
            l_d    = 1'b0;
            b_d    = img_q[7:0];
            cs_add = 1'b1;
            img_d  = {8'h00, img_q[39:8]};
            idx_d  = idx_q - 3'h1;
          end
        end
      end
      LSR_SUM: begin
        if (tx_ready) begin
          v_d  = 1'b0;
          l_d  = 1'b0;
          st_d = LSR_IDLE;
        end
      end
      default: st_d = LSR_IDLE;
    endcase
  end

  // state registers; counter cleared and reset code flagged on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q   <= LSR_IDLE;
      link_q <= LSR_LINK_RESET;                               // [RULE_07]
      addr_q <= LSR_ADDR_RESET;                               // [RULE_14]
      pend_q <= 1'b0;
      rb_q   <= 1'b0;
      idx_q  <= 3'h0;
      img_q  <= 40'h0000000000;
      v_q    <= 1'b0;
      l_q    <= 1'b0;
      b_q    <= 8'h00;
    end else begin
      st_q   <= st_d;
      link_q <= link_d;
      addr_q <= addr_d;
      pend_q <= pend_d;
      rb_q   <= rb_d;
      idx_q  <= idx_d;
      img_q  <= img_d;
      v_q    <= v_d;
      l_q    <= l_d;
      b_q    <= b_d;
    end
  end

  assign mem_address = addr_q;
  assign tx_valid    = v_q;
  assign tx_byte     = b_q;
  assign tx_last     = l_q;
endmodule
`default_nettype wire

/* test/lsr_framer_monitor.sv */
// checker for the response framer ports
`timescale 1ns/1ps
`default_nettype none
module lsr_framer_monitor
  import lsr_pkg::*;
(
  input wire logic       clk,              // clock
  input wire logic       rst,              // reset
  input wire logic       status_request,   // header
  input wire logic       readback_request, // header
  input wire logic       frame_done,       // frame end
  input wire logic [2:0] frame_result,     // outcome
  input wire logic       write_done,       // load
  input wire logic [4:0] write_address,    // load value
  input wire logic [4:0] mem_address,      // counter
  input wire logic       tx_valid,         // valid
  input wire logic [7:0] tx_byte,          // byte
  input wire logic       tx_last,          // checksum
  input wire logic       tx_ready          // taken
);
  logic [2:0] idx_q;
  logic       rb_q;
  logic       done_q;
  wire        take = tx_valid && tx_ready;
  // frame kind and data byte position
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_q  <= 3'h0;
      rb_q   <= 1'h0;
      done_q <= 1'h0;
    end else begin
      if ((status_request || readback_request) && idx_q == 3'h0) rb_q <= readback_request;
      if (take) idx_q <= tx_last ? 3'h0 : idx_q + 3'h1;
      if (take && tx_last) done_q <= rb_q;
      else if (frame_done) done_q <= 1'h0;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  chk_spare_low: assert property (tx_valid && idx_q == 3'h0 |-> !tx_byte[1])
    else $error("spare flag high");
  chk_link_code: assert property (tx_valid && idx_q == 3'h0 |-> tx_byte[7:6] != 2'h1)
    else $error("reserved link code");
  chk_frame_len: assert property (take && tx_last |-> idx_q == (rb_q ? LSR_LEN_READBACK : LSR_LEN_STATUS))
    else $error("wrong byte count");
  chk_count_byte: assert property (tx_valid && rb_q && idx_q == 3'h1 |-> tx_byte == {3'h0, mem_address})
    else $error("counter byte wrong");
  chk_count_step: assert property (frame_done && frame_result == LSR_EV_OK && done_q && !write_done
    |=> mem_address == ($past(mem_address) == LSR_ADDR_LAST ? 5'h00 : $past(mem_address) + 5'h01))
    else $error("counter did not step");
  chk_count_hold: assert property (frame_done && !(frame_result == LSR_EV_OK && done_q) && !write_done
    |=> $stable(mem_address)) else $error("counter moved");
  chk_write_load: assert property (write_done && !frame_done |=> mem_address == $past(write_address))
    else $error("counter not loaded");
  chk_reset_addr: assert property ($fell(rst) |-> mem_address == LSR_ADDR_RESET)
    else $error("counter not cleared");
endmodule
bind lsr_framer lsr_framer_monitor i_lsr_framer_monitor (
  .clk(clk), .rst(rst), .status_request(status_request), .readback_request(readback_request),
  .frame_done(frame_done), .frame_result(frame_result), .write_done(write_done),
  .write_address(write_address), .mem_address(mem_address), .tx_valid(tx_valid),
  .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready));
`default_nettype wire

/* test/lsr_master_model.sv */
// master node model: header, response intake, checksum check
`timescale 1ns/1ps
`default_nettype none
module lsr_master_model
  import lsr_pkg::*;
(
  input  wire logic       clk,              // clock
  input  wire logic       tx_valid,         // valid
  input  wire logic [7:0] tx_byte,          // byte
  input  wire logic       tx_last,          // checksum
  output var  logic       tx_ready,         // taken
  output var  logic       status_request,   // header
  output var  logic       readback_request, // header
  output var  logic       frame_done,       // frame end
  output var  logic [2:0] frame_result      // outcome
);
  // idle levels
  initial begin
    tx_ready = 1'h0;
    status_request = 1'h0;
    readback_request = 1'h0;
    frame_done = 1'h0;
    frame_result = 3'h0;
  end
  // slow mode drops tx_ready every other cycle
  task automatic xfer(input logic rb, input logic [7:0] pid, input logic [2:0] res,
                      input logic slow, output logic [47:0] d, output logic ok);
    logic [8:0] s;
    int n;
    int t;
    s = {1'h0, pid};
    n = 0;
    t = 0;
    ok = 1'h0;
    d = 48'h0;
    if (rb) readback_request <= 1'h1;
    else status_request <= 1'h1;
    @(posedge clk);
    readback_request <= 1'h0;
    status_request <= 1'h0;
    while (t < 100) begin
      tx_ready <= slow ? ~tx_ready : 1'h1;
      @(posedge clk);
      t++;
      if (tx_valid && tx_ready && tx_last) begin
        ok = (tx_byte === ~s[7:0]);
        break;
      end
      if (tx_valid && tx_ready) begin
        d[n*8 +: 8] = tx_byte;
        s = s[7:0] + tx_byte;
        s = s[7:0] + s[8];
        n++;
      end
    end
    tx_ready <= 1'h0;
    frame_done <= 1'h1;
    frame_result <= ok ? res : LSR_EV_CHECKSUM;
    @(posedge clk);
    frame_done <= 1'h0;
  endtask
endmodule
`default_nettype wire

/* test/lsr_framer_test.sv */
// self-checking bench for the response framer
`timescale 1ns/1ps
`default_nettype none
module lsr_framer_test;
  import lsr_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [3:0]  address;
  logic        read, write, waitrequest, temp_warning, write_done, ok, unc;
  logic [31:0] writedata, readdata, rd;
  logic [1:0]  fault_class;
  logic [4:0]  write_address, mem_address, cnt;
  logic [23:0] mem_data;
  logic        tx_valid, tx_last, tx_ready, status_request, readback_request, frame_done;
  logic [7:0]  tx_byte, loc, pid_s, pid_r;
  logic [2:0]  frame_result, res, link;
  logic [47:0] d;
  logic [2:0]  codes [5] = '{LSR_EV_OK, LSR_EV_DATA, LSR_EV_CHECKSUM, LSR_EV_FRAMING, LSR_EV_PARITY};
  int          failures = 0;
  int          checks_done = 0;
  int          seed = 57;

  always #5 clk = ~clk;
  // memory contents differ in every byte
  function automatic logic [23:0] mem_fn(input logic [4:0] a);
    return {a, 3'h6, ~a, 3'h1, a ^ 5'h15, 3'h3};
  endfunction
  assign mem_data = mem_fn(mem_address);

  lsr_framer i_lsr_framer (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .temp_warning(temp_warning), .fault_class(fault_class), .status_request(status_request),
    .readback_request(readback_request), .frame_done(frame_done), .frame_result(frame_result),
    .write_done(write_done), .write_address(write_address), .mem_address(mem_address),
    .mem_data(mem_data), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready));
  lsr_master_model i_lsr_master_model (
    .clk(clk), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready),
    .status_request(status_request), .readback_request(readback_request),
    .frame_done(frame_done), .frame_result(frame_result));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    // look at waitrequest and readdata while settled, before each rising edge
    @(negedge clk);
    while (waitrequest !== 1'h0 && t < 50) begin
      @(negedge clk);
      t++;
    end
    if (t == 50) failures++;
    rd = readdata;
    @(posedge clk);
    read <= 1'h0;
    write <= 1'h0;
    @(posedge clk);
  endtask
  task automatic do_reset;
    rst <= 1'h1;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    cnt = LSR_ADDR_RESET;
    link = LSR_LINK_RESET;
    unc = 1'h1;
    loc = LSR_LOC_DEFAULT;
    pid_s = LSR_PID_STATUS;
    pid_r = LSR_PID_READBACK;
  endtask
  // one frame, its response compared, expectations moved on
  task automatic frame(input logic rb, input logic slow);
    i_lsr_master_model.xfer(rb, rb ? pid_r : pid_s, res, slow, d, ok);
    chk(ok, 1'h1);
    chk(d[7:0], {link, unc, fault_class, 1'h0, temp_warning});
    if (!rb) chk(d[15:8], loc);
    if (rb) chk(d[39:8], {mem_fn(cnt), 3'h0, cnt});
    if (rb && res == LSR_EV_OK) cnt = (cnt == LSR_ADDR_LAST) ? 5'h00 : cnt + 5'h01;
    link = res;
  endtask
  task automatic results;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {address, read, write, writedata, temp_warning, fault_class, write_done, write_address, res} = '0;
    do_reset;
    frame(1'h0, 1'h0);
    $display("test reset_status done");
    pid_s = $random(seed);
    pid_r = $random(seed);
    av(1'h1, 4'h1, {16'h0, pid_r, pid_s});
    loc = $random(seed);
    av(1'h1, 4'h0, {24'h0, loc});
    unc = 1'h0;
    av(1'h0, 4'h2, 32'h0);
    chk({rd[20:16], rd[7:0]}, {cnt, loc});
    chk(rd[15:8], {link, unc, fault_class, 1'h0, temp_warning});
    av(1'h0, 4'hF, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    // every outcome code, random temperature warning, each fault class
    for (int i = 0; i < 12; i++) begin
      temp_warning <= $random(seed);
      fault_class <= (i % 3 == 0) ? LSR_FAULT_NONE : ((i % 3 == 1) ? LSR_FAULT_OVERTMP : LSR_FAULT_NVMPRG);
      res <= codes[i % 5];
      @(posedge clk);
      frame(1'h0, i[0]);
    end
    $display("test status done");
    // readback sweep with failures, a load and the wrap
    for (int i = 0; i < 24; i++) begin
      res <= (i % 4 == 3) ? codes[1 + (i / 4) % 4] : LSR_EV_OK;
      if (i == 9) begin
        write_address <= 5'h0E;
        write_done <= 1'h1;
        @(posedge clk);
        write_done <= 1'h0;
        cnt = write_address;
      end
      @(posedge clk);
      frame(1'h1, i[1]);
    end
    $display("test readback done");
    do_reset;
    chk(mem_address, LSR_ADDR_RESET);
    res <= LSR_EV_OK;
    @(posedge clk);
    frame(1'h1, 1'h0);
    $display("test second_reset done");
    results;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results;
  end
endmodule
`default_nettype wire
